// ==== rtl/timer_channel_mode_control.sv ====
`timescale 1ns/1ps
// Behaviour
// - Code 000 keeps the prepare signal unchanged, compare ignored.
// - Code 001 drives prepare high on counter equal to compare.
// - Code 010 drives prepare low on counter equal to compare.
// - Code 011 toggles prepare on each counter match.
// - Code 100 forces prepare low, code 101 forces it high.
// - PWM0: up high below compare; down low above compare, else high.
// - PWM1: up low below compare; down high above compare, else low.
// - PWM level changes only on entry from timing or comparison change.
// - High prepare is active; outputs apply their own polarity bits.
// - Compare control and shadow bit locked at protection 11 in output mode.
// - Shadow enabled: compare reloads on update event; else writes act at once.
// - Channel io select writable only while channel is disabled.
// - Io select 00 is output, 01 input from filtered channel input.
// - Filter counts equal consecutive samples, accepts level at configured count.
// - Filter code 0 bypasses; codes 1 to 3 need 2, 4, 8 kernel samples.
// - Codes 4 to 15 sample at dead-time clock divided by 2 to 32.
// - Capture prescaler captures every 1, 2, 4 or 8 qualified edges.
// - Prescaler edge counter is cleared whenever channel enable is clear.
// - Field layout: compare 6:4, shadow 3, mode 1:0, filter 7:4, prescaler 3:2.
// - Enable lets the channel output drive active state (cen gates the complementary one), or lets captures occur.
module timer_channel_mode_control (
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output wire logic        s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output wire logic        s_axi_wready_o,
	output wire logic [1:0]  s_axi_bresp_o,
	output wire logic        s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output wire logic        s_axi_arready_o,
	output wire logic [31:0] s_axi_rdata_o,
	output wire logic [1:0]  s_axi_rresp_o,
	output wire logic        s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Surrounding timer
	input  wire logic [15:0] counter_value_i,
	input  wire logic        count_down_i,
	input  wire logic        update_event_i,
	input  wire logic [1:0]  protection_level_i,
	input  wire logic        single_pulse_select_i,
	input  wire logic        dead_time_sample_clock_i,
	// Channel pins and events
	input  wire logic        channel_input_i,
	output wire logic        output_prepare_signal_o,
	output wire logic        channel_output_o,
	output wire logic        complementary_output_o,
	output wire logic        capture_event_o
);

	tcm_pkg::chan_state_t state_ff;
	tcm_pkg::chan_state_t nxt_state;

	logic       filtered_level;
	logic       sample_en;
	logic [3:0] flt_code;
	logic [2:0] cmp_ctl;
	logic [1:0] io_sel;
	logic [1:0] psc_code;
	logic       shadow_en;
	logic       out_mode;
	logic       in_mode;
	logic [15:0] active_cmp;
	logic       match;
	logic       pwm_base;
	logic       pwm_lvl;
	logic       rise;
	logic       fall;
	logic       qual_edge;
	logic [2:0] psc_mask;
	logic [4:0] div_top;
	logic       wr_go;
	logic [7:0] cfg_wr;
	logic [7:0] cfg_new;

	// Field views of the shared configuration byte
	assign cmp_ctl   = state_ff.cfg[tcm_pkg::CMP_CTL_LSB +: 3];
	assign shadow_en = state_ff.cfg[tcm_pkg::SHADOW_BIT];
	assign io_sel    = state_ff.cfg[tcm_pkg::MODE_LSB +: 2];
	assign flt_code  = state_ff.cfg[tcm_pkg::FLT_LSB +: 4];
	assign psc_code  = state_ff.cfg[tcm_pkg::PSC_LSB +: 2];
	assign out_mode  = (io_sel == tcm_pkg::IO_OUTPUT);
	assign in_mode   = (io_sel == tcm_pkg::IO_INPUT);

	// Filter sample rate: kernel clock for low codes, divided dead-time clock above
	assign div_top   = 5'((6'h01 << tcm_pkg::FLT_DIVLOG[flt_code]) - 6'h01);
	assign sample_en = (flt_code < tcm_pkg::FLT_FIRST_DTS) ? 1'b1 :
	                   (dead_time_sample_clock_i && (state_ff.div_cnt == div_top));

	input_filter u_filter (
		.mclk_i      (mclk_i),
		.sys_rst_i   (sys_rst_i),
		.sample_en_i (sample_en),
		.bypass_i    (flt_code == tcm_pkg::FLT_OFF),
		.need_i      (tcm_pkg::FLT_TIMES[flt_code]),
		.din_i       (channel_input_i),
		.level_o     (filtered_level)
	);

	// Compare source: shadow copy only when the shadow is enabled
	assign active_cmp = shadow_en ? state_ff.shadow : state_ff.cmp;
	assign match      = (counter_value_i == active_cmp);

	// PWM0 base level, inverted for PWM1
	assign pwm_base = count_down_i ? !(counter_value_i > active_cmp) :
	                                 (counter_value_i < active_cmp);
	assign pwm_lvl  = (cmp_ctl == tcm_pkg::CMP_PWM1) ? !pwm_base : pwm_base;

	// Edge qualification on the filtered input, polarity pair picks the edge
	assign rise      = filtered_level && !state_ff.flt_prev;
	assign fall      = !filtered_level && state_ff.flt_prev;
	assign qual_edge = in_mode && state_ff.en &&
	                   ((!state_ff.cpol && !state_ff.pol && rise) ||
	                    (!state_ff.cpol && state_ff.pol && fall) ||
	                    (state_ff.cpol && state_ff.pol && (rise || fall)));

	// Prescaler wrap mask per code
	always_comb begin
		case (psc_code)
			2'h0: psc_mask = 3'h0;
			2'h1: psc_mask = 3'h1;
			2'h2: psc_mask = 3'h3;
			2'h3: psc_mask = 3'h7;
			default: psc_mask = 3'h0;
		endcase
	end

	// Write to the configuration byte with mode and protection locks
	assign wr_go  = state_ff.aw_held && state_ff.w_held && !state_ff.bvalid;
	assign cfg_wr = state_ff.wdata[7:0];
	always_comb begin
		cfg_new = cfg_wr;
		if (state_ff.en) begin
			cfg_new[tcm_pkg::MODE_LSB +: 2] = io_sel;
		end
		// Lock compares against the stored mode, so a write cannot unlock itself
		if ((protection_level_i == tcm_pkg::LOCK_FULL) && out_mode) begin
			cfg_new[tcm_pkg::CMP_CTL_LSB +: 3] = cmp_ctl;
			cfg_new[tcm_pkg::SHADOW_BIT]       = shadow_en;
		end
	end

	// Next state of the whole channel
	always_comb begin
		nxt_state = state_ff;

		// Write address and data are taken in either order
		if (s_axi_awvalid_i && state_ff.awready) begin
			nxt_state.aw_held = 1'b1;
			nxt_state.awaddr  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && state_ff.wready) begin
			nxt_state.w_held = 1'b1;
			nxt_state.wdata  = s_axi_wdata_i;
			nxt_state.wstrb  = s_axi_wstrb_i;
		end
		if (state_ff.bvalid && s_axi_bready_i) begin
			nxt_state.bvalid = 1'b0;
		end

		// Shadow follows the written value unless shadowing is on
		if (!shadow_en) begin
			nxt_state.shadow = state_ff.cmp;
		end else if (update_event_i) begin
			nxt_state.shadow = state_ff.cmp;
		end

		// Register write once both halves are held
		if (wr_go) begin
			nxt_state.aw_held = 1'b0;
			nxt_state.w_held  = 1'b0;
			nxt_state.bvalid  = 1'b1;
			nxt_state.bresp   = tcm_pkg::RESP_OKAY;
			case (state_ff.awaddr)
				tcm_pkg::CFG_OFFSET: begin
					if (state_ff.wstrb[0]) begin
						nxt_state.cfg = cfg_new;
					end
				end
				tcm_pkg::CMP_OFFSET: begin
					if (state_ff.wstrb[0]) begin
						nxt_state.cmp[7:0] = state_ff.wdata[7:0];
					end
					if (state_ff.wstrb[1]) begin
						nxt_state.cmp[15:8] = state_ff.wdata[15:8];
					end
					if (!shadow_en) begin
						nxt_state.shadow = nxt_state.cmp;
					end
				end
				tcm_pkg::EN_OFFSET: begin
					if (state_ff.wstrb[0]) begin
						nxt_state.en  = state_ff.wdata[tcm_pkg::EN_BIT];
						nxt_state.cen = state_ff.wdata[tcm_pkg::CEN_BIT];
						// Polarity is frozen at the two upper protection levels
						if (!protection_level_i[1]) begin
							nxt_state.pol  = state_ff.wdata[tcm_pkg::POL_BIT];
							nxt_state.cpol = state_ff.wdata[tcm_pkg::CPOL_BIT];
						end
					end
				end
				tcm_pkg::STAT_OFFSET: begin
					nxt_state.bresp = tcm_pkg::RESP_OKAY; // Read-only, write dropped
				end
				default: begin
					nxt_state.bresp = tcm_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Read path answers one cycle after the address is taken
		if (state_ff.rvalid && s_axi_rready_i) begin
			nxt_state.rvalid = 1'b0;
		end
		if (s_axi_arvalid_i && state_ff.arready) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp  = tcm_pkg::RESP_OKAY;
			case (s_axi_araddr_i)
				tcm_pkg::CFG_OFFSET: nxt_state.rdata = {24'h00_0000, state_ff.cfg};
				tcm_pkg::CMP_OFFSET: nxt_state.rdata = {16'h0000, state_ff.cmp};
				tcm_pkg::EN_OFFSET: begin
					nxt_state.rdata = {28'h000_0000, state_ff.cpol, state_ff.cen,
					                   state_ff.pol, state_ff.en};
				end
				tcm_pkg::STAT_OFFSET: begin
					nxt_state.rdata = {state_ff.cap_count, 13'h0000, filtered_level,
					                   state_ff.chan_out, state_ff.prep};
				end
				default: begin
					nxt_state.rdata = 32'h0000_0000;
					nxt_state.rresp = tcm_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Ready flags stay low while a transfer is held or answered
		nxt_state.awready = !nxt_state.aw_held && !nxt_state.bvalid;
		nxt_state.wready  = !nxt_state.w_held && !nxt_state.bvalid;
		nxt_state.arready = !nxt_state.rvalid;

		// Dead-time divider runs only on its own ticks
		if (dead_time_sample_clock_i) begin
			nxt_state.div_cnt = (state_ff.div_cnt >= div_top) ? 5'h00 :
			                    5'(state_ff.div_cnt + 5'h01);
		end

		// Output compare generator
		nxt_state.pwm_prev = pwm_lvl;
		nxt_state.ctl_prev = cmp_ctl;
		if (out_mode) begin
			case (cmp_ctl)
				tcm_pkg::CMP_TIMING: nxt_state.prep = state_ff.prep;
				tcm_pkg::CMP_SET: begin
					if (match) begin
						nxt_state.prep = 1'b1;
					end
				end
				tcm_pkg::CMP_CLEAR: begin
					if (match) begin
						nxt_state.prep = 1'b0;
					end
				end
				tcm_pkg::CMP_TOGGLE: begin
					if (match) begin
						nxt_state.prep = !state_ff.prep;
					end
				end
				tcm_pkg::CMP_FORCE_LO: nxt_state.prep = 1'b0;
				tcm_pkg::CMP_FORCE_HI: nxt_state.prep = 1'b1;
				tcm_pkg::CMP_PWM0, tcm_pkg::CMP_PWM1: begin
					// Level moves on a new comparison result or on entry from timing
					if ((pwm_lvl != state_ff.pwm_prev) ||
					    (state_ff.ctl_prev == tcm_pkg::CMP_TIMING)) begin
						nxt_state.prep = pwm_lvl;
					end
				end
				default: nxt_state.prep = state_ff.prep;
			endcase
		end

		// Pins: high prepare is active, each output has its own polarity
		nxt_state.chan_out = out_mode && nxt_state.en &&
		                     (nxt_state.prep ^ nxt_state.pol);
		nxt_state.comp_out = out_mode && nxt_state.cen &&
		                     (nxt_state.prep ^ nxt_state.cpol);

		// Capture prescaler and capture of the counter into the compare register
		nxt_state.flt_prev = filtered_level;
		nxt_state.capture  = 1'b0;
		if (!state_ff.en) begin
			nxt_state.psc_cnt = 3'h0;
		end else if (qual_edge) begin
			if ((state_ff.psc_cnt & psc_mask) == psc_mask) begin
				nxt_state.psc_cnt   = 3'h0;
				nxt_state.capture   = 1'b1;
				nxt_state.cmp       = counter_value_i; // Capture beats a bus write
				nxt_state.cap_count = state_ff.cap_count + 16'h0001;
			end else begin
				nxt_state.psc_cnt = 3'(state_ff.psc_cnt + 3'h1);
			end
		end
	end

	// State register
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff        <= '0;
			state_ff.cfg    <= tcm_pkg::CFG_RESET;
			state_ff.cmp    <= tcm_pkg::CMP_RESET;
			state_ff.shadow <= tcm_pkg::CMP_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Single pulse mode only relaxes what software must do with the shadow
	// (the device itself behaves the same either way), so it is not read here.

	// Outputs straight from the state register
	assign s_axi_awready_o         = state_ff.awready;
	assign s_axi_wready_o          = state_ff.wready;
	assign s_axi_bresp_o           = state_ff.bresp;
	assign s_axi_bvalid_o          = state_ff.bvalid;
	assign s_axi_arready_o         = state_ff.arready;
	assign s_axi_rdata_o           = state_ff.rdata;
	assign s_axi_rresp_o           = state_ff.rresp;
	assign s_axi_rvalid_o          = state_ff.rvalid;
	assign output_prepare_signal_o = state_ff.prep;
	assign channel_output_o        = state_ff.chan_out;
	assign complementary_output_o  = state_ff.comp_out;
	assign capture_event_o         = state_ff.capture;

endmodule : timer_channel_mode_control

// ==== pkg/tcm_pkg.sv ====
package tcm_pkg;

	// Register byte addresses on the AXI4-Lite port
	localparam int                ADDR_W       = 8;
	localparam logic [ADDR_W-1:0] CFG_OFFSET   = 8'h00;
	localparam logic [ADDR_W-1:0] CMP_OFFSET   = 8'h04;
	localparam logic [ADDR_W-1:0] STAT_OFFSET  = 8'h0C;
	localparam logic [ADDR_W-1:0] EN_OFFSET    = 8'h20;

	// Values after reset
	localparam logic [7:0]  CFG_RESET = 8'h00;
	localparam logic [15:0] CMP_RESET = 16'h0000;

	// Field positions in channel_mode_config
	localparam int CMP_CTL_LSB = 4;
	localparam int SHADOW_BIT  = 3;
	localparam int MODE_LSB    = 0;
	localparam int FLT_LSB     = 4;
	localparam int PSC_LSB     = 2;

	// Bit positions in channel_enable_register
	localparam int EN_BIT   = 0;
	localparam int POL_BIT  = 1;
	localparam int CEN_BIT  = 2;
	localparam int CPOL_BIT = 3;

	// Compare output control codes
	localparam logic [2:0] CMP_TIMING   = 3'h0;
	localparam logic [2:0] CMP_SET      = 3'h1;
	localparam logic [2:0] CMP_CLEAR    = 3'h2;
	localparam logic [2:0] CMP_TOGGLE   = 3'h3;
	localparam logic [2:0] CMP_FORCE_LO = 3'h4;
	localparam logic [2:0] CMP_FORCE_HI = 3'h5;
	localparam logic [2:0] CMP_PWM0     = 3'h6;
	localparam logic [2:0] CMP_PWM1     = 3'h7;

	// Channel io select codes and the locking protection level
	localparam logic [1:0] IO_OUTPUT = 2'h0;
	localparam logic [1:0] IO_INPUT  = 2'h1;
	localparam logic [1:0] LOCK_FULL = 2'h3;

	// Filter: equal samples needed and log2 of the sample clock divider, per code
	localparam logic [15:0][3:0] FLT_TIMES = {4'h8, 4'h6, 4'h5, 4'h8, 4'h6, 4'h5, 4'h8, 4'h6,
	                                          4'h8, 4'h6, 4'h8, 4'h6, 4'h8, 4'h4, 4'h2, 4'h1};
	localparam logic [15:0][2:0] FLT_DIVLOG = {3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3,
	                                           3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
	localparam logic [3:0]       FLT_OFF       = 4'h0;
	localparam logic [3:0]       FLT_FIRST_DTS = 4'h4;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       level;
		logic [3:0] run;
	} filter_state_t;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              aw_held;
		logic              w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [7:0]        cfg;
		logic [15:0]       cmp;
		logic [15:0]       shadow;
		logic              en;
		logic              pol;
		logic              cen;
		logic              cpol;
		logic              prep;
		logic              pwm_prev;
		logic [2:0]        ctl_prev;
		logic              flt_prev;
		logic [2:0]        psc_cnt;
		logic              capture;
		logic [15:0]       cap_count;
		logic [4:0]        div_cnt;
		logic              chan_out;
		logic              comp_out;
	} chan_state_t;

endpackage : tcm_pkg

// ==== rtl/input_filter.sv ====
`timescale 1ns/1ps
// Digital level filter: a new level is accepted after enough equal samples
module input_filter (
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       sample_en_i,
	input  wire logic       bypass_i,
	input  wire logic [3:0] need_i,
	input  wire logic       din_i,
	output wire logic       level_o
);

	tcm_pkg::filter_state_t state_ff;
	tcm_pkg::filter_state_t nxt_state;

	assign level_o = state_ff.level;

	// Run length counts samples that differ from the accepted level
	always_comb begin
		nxt_state = state_ff;
		if (bypass_i) begin
			nxt_state.level = din_i;
			nxt_state.run   = 4'h0;
		end else if (sample_en_i) begin
			if (din_i == state_ff.level) begin
				nxt_state.run = 4'h0; // Any glitch back restarts the count
			end else if ((state_ff.run + 4'h1) >= need_i) begin
				nxt_state.level = din_i;
				nxt_state.run   = 4'h0;
			end else begin
				nxt_state.run = state_ff.run + 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

endmodule : input_filter

// ==== verif/tcm_monitor.sv ====
`timescale 1ns/1ps
// Handshake checks on the register port of the channel block
module tcm_monitor (
	input wire logic        mclk_i,
	input wire logic        sys_rst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i
);
	default clocking dcb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);

	// A write is both halves taken together, a read its address alone
	sequence s_wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence

	a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_o)
		else $error("write response late");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid_o)
		else $error("read data late");
	a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
		s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
	a_bvalid_clears: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response repeated");
	a_rvalid_clears: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read data repeated");
	// Only one write may be under way, so both readies stay low while its response is pending
	a_write_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while response pending");
	a_read_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while data pending");
endmodule : tcm_monitor

bind timer_channel_mode_control tcm_monitor u_tcm_monitor (.mclk_i, .sys_rst_i,
	.s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
	.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rvalid_o, .s_axi_rready_i);

// ==== verif/pin_model.sv ====
`timescale 1ns/1ps
// Far-side driver of the channel input pin; it rests low between pulses
module pin_model (
	input  wire logic mclk_i,
	output logic      channel_input_o
);
	initial channel_input_o = 1'b0;

	// Long low gap so that the filter codes up to 4 that the tests use settle again
	task automatic pulse(input int width);
		channel_input_o <= 1'b1;
		repeat (width) @(posedge mclk_i);
		channel_input_o <= 1'b0;
		repeat (20) @(posedge mclk_i);
	endtask : pulse
endmodule : pin_model

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin \
	checks++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); \
	end \
end
module tb_top;
	typedef struct packed {
		logic [2:0] st;
		logic [2:0] ctl;
		logic [2:0] exp;
	} row_t;
	logic        mclk_i, sys_rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
	logic        s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, protection_level_i;
	logic [15:0] counter_value_i;
	logic        count_down_i, update_event_i, single_pulse_select_i;
	logic        dead_time_sample_clock_i, channel_input_i, capture_event_o;
	logic        output_prepare_signal_o, channel_output_o, complementary_output_o;
	int          n_fail, checks, ncap;
	row_t        rows [8];
	int          flt [6][3];

	timer_channel_mode_control u_timer_channel_mode_control (.mclk_i, .sys_rst_i,
		.s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
		.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
		.s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
		.s_axi_rvalid_o, .s_axi_rready_i, .counter_value_i, .count_down_i, .update_event_i,
		.protection_level_i, .single_pulse_select_i, .dead_time_sample_clock_i,
		.channel_input_i, .output_prepare_signal_o, .channel_output_o,
		.complementary_output_o, .capture_event_o);
	pin_model u_pin_model (.mclk_i(mclk_i), .channel_input_o(channel_input_i));

	// Clock and capture counter
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) if (capture_event_o === 1'b1) ncap++;

	// Write master: each half released as taken, then wait for the response
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge mclk_i);
		s_axi_awaddr_i  <= a;
		s_axi_wdata_i   <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i  <= 1'b1;
		// Response is accepted a cycle late, so it must stand unasked for a cycle
		do begin
			@(posedge mclk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o && !s_axi_bready_i) s_axi_bready_i <= 1'b1;
		end while (!(s_axi_bvalid_o === 1'b1 && s_axi_bready_i === 1'b1));
		s_axi_bready_i <= 1'b0;
		`CHK(s_axi_bresp_o, er)
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge mclk_i);
		s_axi_araddr_i  <= a;
		s_axi_arvalid_i <= 1'b1;
		do begin
			@(posedge mclk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o && !s_axi_rready_i) s_axi_rready_i <= 1'b1;
		end while (!(s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1));
		s_axi_rready_i <= 1'b0;
		`CHK(s_axi_rdata_o, ed)
		`CHK(s_axi_rresp_o, er)
	endtask : rd

	// Complementary output runs with inverted polarity in the compare rows
	task automatic chk_out(input logic e);
		`CHK(output_prepare_signal_o, e)
		`CHK(channel_output_o, e)
		`CHK(complementary_output_o, ~e)
	endtask : chk_out

	// Mode changes need the channel disabled first
	task automatic setup_in(input logic [3:0] f, input logic [1:0] p);
		wr(8'h20, 32'h0000_0000, 2'h0);
		wr(8'h00, {24'h0, f, p, 2'h1}, 2'h0);
		wr(8'h20, 32'h0000_0001, 2'h0);
		ncap = 0;
	endtask : setup_in

	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// Whole run is under two thousand cycles
	initial begin
		#100us;
		n_fail++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		end_of_test();
	end

	initial begin
		// Rows: start code, compare code, levels below / after match / counting down
		rows = '{'{3'h5, 3'h0, 3'h7}, '{3'h4, 3'h1, 3'h3}, '{3'h5, 3'h2, 3'h4},
			'{3'h4, 3'h3, 3'h3}, '{3'h5, 3'h4, 3'h0}, '{3'h4, 3'h5, 3'h7},
			'{3'h0, 3'h6, 3'h5}, '{3'h0, 3'h7, 3'h2}};
		flt = '{'{1, 1, 0}, '{1, 3, 1}, '{3, 6, 0}, '{3, 10, 1}, '{4, 8, 0}, '{4, 16, 1}};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = '0;
		{s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		{counter_value_i, count_down_i, update_event_i, protection_level_i} = '0;
		s_axi_wstrb_i = 4'hF;
		single_pulse_select_i = 1'b1; // PWM rows run without the shadow
		dead_time_sample_clock_i = 1'b1;
		n_fail = 0;
		checks = 0;
		ncap = 0;
		sys_rst_i = 1'b1;
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		`CHK(output_prepare_signal_o, 1'b0)
		rd(8'h00, 32'h0000_0000, 2'h0);
		rd(8'h04, 32'h0000_0000, 2'h0);
		rd(8'h20, 32'h0000_0000, 2'h0);
		rd(8'h10, 32'h0000_0000, 2'h2);
		wr(8'h10, 32'hFFFF_FFFF, 2'h2);
		$display("reset and map test done");

		wr(8'h20, 32'h0000_000D, 2'h0);
		wr(8'h04, 32'h0000_000A, 2'h0);
		foreach (rows[i]) begin
			counter_value_i <= 16'h0005;
			count_down_i    <= 1'b0;
			wr(8'h00, 32'h0000_0040, 2'h0);
			wr(8'h00, {25'h0, rows[i].st, 4'h0}, 2'h0);
			wr(8'h00, {25'h0, rows[i].ctl, 4'h0}, 2'h0);
			repeat (3) @(posedge mclk_i);
			chk_out(rows[i].exp[2]);
			counter_value_i <= 16'h000A;
			@(posedge mclk_i);
			counter_value_i <= 16'h000F;
			repeat (3) @(posedge mclk_i);
			chk_out(rows[i].exp[1]);
			count_down_i    <= 1'b1;
			counter_value_i <= 16'h0007;
			repeat (3) @(posedge mclk_i);
			chk_out(rows[i].exp[0]);
			$display("compare row %0d done", i);
		end

		// Locked fields and the mode bits under enable
		protection_level_i <= 2'h3;
		wr(8'h00, 32'h0000_0050, 2'h0);
		rd(8'h00, 32'h0000_0070, 2'h0);
		protection_level_i <= 2'h0;
		wr(8'h00, 32'h0000_0071, 2'h0);
		rd(8'h00, 32'h0000_0070, 2'h0);
		wr(8'h00, 32'h0000_0050, 2'h0);
		wr(8'h20, 32'h0000_0000, 2'h0);
		repeat (2) @(posedge mclk_i);
		`CHK(channel_output_o, 1'b0)
		wr(8'h20, 32'h0000_000D, 2'h0);
		$display("lock and enable test done");

		// Shadowed compare only moves on an update event
		wr(8'h00, 32'h0000_0040, 2'h0);
		wr(8'h00, 32'h0000_0018, 2'h0);
		wr(8'h04, 32'h0000_0014, 2'h0);
		for (int k = 0; k < 2; k++) begin
			update_event_i  <= (k == 1);
			@(posedge mclk_i);
			update_event_i  <= 1'b0;
			counter_value_i <= 16'h0014;
			@(posedge mclk_i);
			counter_value_i <= 16'h0000;
			repeat (3) @(posedge mclk_i);
			`CHK(output_prepare_signal_o, k[0])
		end
		$display("shadow test done");

		// Capture prescaler over all codes, then its clear on disable
		counter_value_i <= 16'h1234;
		for (int p = 0; p < 4; p++) begin
			setup_in(4'h1, p[1:0]);
			repeat (8) u_pin_model.pulse(4);
			`CHK(ncap, 8 >> p)
		end
		rd(8'h04, 32'h0000_1234, 2'h0);
		setup_in(4'h1, 2'h1);
		repeat (3) u_pin_model.pulse(4);
		wr(8'h20, 32'h0000_0000, 2'h0);
		wr(8'h20, 32'h0000_0001, 2'h0);
		u_pin_model.pulse(4);
		`CHK(ncap, 1)
		$display("prescaler test done");

		// Pulses just short of and past each filter's count
		for (int k = 0; k < 6; k++) begin
			setup_in(flt[k][0][3:0], 2'h0);
			u_pin_model.pulse(flt[k][1]);
			`CHK(ncap, flt[k][2])
		end
		$display("filter test done");

		// Reset in mid-run brings the configuration back to output mode
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		`CHK(s_axi_awready_o, 1'b0)
		sys_rst_i <= 1'b0;
		rd(8'h00, 32'h0000_0000, 2'h0);
		`CHK(channel_output_o, 1'b0)
		$display("mid-run reset test done");
		end_of_test();
	end
endmodule : tb_top
